/* File: logic/uip_top.sv */
// User interface and power control: volume, mute, on/off, icons, digit, power.
// Assumes the main control logic answers the volume and shutdown handshakes.
//
// Contract
// - Up or down request in idle starts check
// - At limit return idle without change request
// - Otherwise step counter once in requested direction
// - Hold change request until register update done
// - Mute toggles per button edge; pulse output
// - Power state toggles per press, preset on
// - Press while on requests shutdown, not cutoff
// - Play mode codes 000-011 decoded to one icon each; 100-111 light none
// - Error beats download beats all others
// - Registered mute/error/download; volume, battery bars
// - Track number drives seven-segment digit
// - Hold logic reset until supply good
// - Release reset two wait cycles after good
// - Supply loss or off asserts shutdown request
// - Shutdown complete asserts supply cutoff
// - Codes 000 play,001 rew,010 stop,011 ffwd
// - Six-bit saturating volume level output
`timescale 1ns/100ps
`default_nettype none
module uip_top
    import uip_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire uip_buttons_t buttons,
    input wire logic register_update_done,
    input wire logic [2:0] play_mode_code,
    input wire logic error_icon_request,
    input wire logic download_icon_request,
    input wire logic [1:0] battery_level,
    input wire logic [3:0] track_number,
    input wire logic supply_good,
    input wire logic shutdown_complete,
    output logic volume_change_request,
    output logic [5:0] volume_level,
    output logic mute_state,
    output logic mute_change_pulse,
    output logic power_on_state,
    output logic logic_reset,
    output logic shutdown_request,
    output logic supply_cutoff,
    output uip_icons_t icons,
    output logic [6:0] segments
);
    ////////////////////////////////////////////////////////////////////////////
    // Edge detection
    logic [3:0] rise;
    logic up_p, down_p, mute_p, power_p;

    uip_edge #(.N(4)) u_edge (
        .sys_clk(sys_clk),
        .srst(srst),
        .clk_en(clk_en),
        .btn_in(buttons),
        .rise_pulse(rise)
    );

    assign {up_p, down_p, mute_p, power_p} = rise;

    ////////////////////////////////////////////////////////////////////////////
    // Reset control and power sequencing
    typedef enum logic [1:0] {PW_HOLD, PW_RUN, PW_DOWN, PW_CUT} uip_pwr_t;
    uip_pwr_t pwr_reg, pwr_next;
    logic [1:0] wait_reg, wait_next;
    logic run_rst;

    always_comb begin
        pwr_next = pwr_reg;
        wait_next = wait_reg;
        unique case (pwr_reg)
            PW_HOLD: begin
                if (!supply_good) begin
                    wait_next = 2'h0;
                end else if (wait_reg == WAIT_LAST) begin
                    pwr_next = PW_RUN;
                end else begin
                    wait_next = wait_reg + 2'h1;
                end
            end
            PW_RUN: begin
                if (!supply_good || !power_on_state) begin
                    pwr_next = PW_DOWN;
                end
            end
            PW_DOWN: begin
                if (shutdown_complete) begin
                    pwr_next = PW_CUT;
                end
            end
            PW_CUT: pwr_next = PW_CUT;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwr_reg <= PW_HOLD;
            wait_reg <= 2'h0;
        end else if (clk_en) begin
            pwr_reg <= pwr_next;
            wait_reg <= wait_next;
        end
    end

    assign logic_reset = (pwr_reg == PW_HOLD);
    assign shutdown_request = (pwr_reg == PW_DOWN);
    assign supply_cutoff = (pwr_reg == PW_CUT);
    assign run_rst = srst | logic_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Volume state machine
    typedef enum logic [1:0] {VS_IDLE, VS_CHECK, VS_STEP, VS_HOLD} uip_vol_t;
    uip_vol_t vol_reg, vol_next;
    logic dir_up_reg, dir_up_next;
    logic [5:0] level_reg, level_next;

    always_comb begin
        vol_next = vol_reg;
        dir_up_next = dir_up_reg;
        level_next = level_reg;
        unique case (vol_reg)
            VS_IDLE: begin
                if (up_p || down_p) begin
                    vol_next = VS_CHECK;
                    dir_up_next = up_p;
                end
            end
            VS_CHECK: begin
                if ((dir_up_reg && level_reg == VOL_MAX) || (!dir_up_reg && level_reg == VOL_MIN)) begin
                    vol_next = VS_IDLE;
                end else begin
                    vol_next = VS_STEP;
                end
            end
            VS_STEP: begin
                level_next = dir_up_reg ? level_reg + 6'h01 : level_reg - 6'h01;
                vol_next = VS_HOLD;
            end
            VS_HOLD: begin
                if (register_update_done) begin
                    vol_next = VS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (run_rst) begin
            vol_reg <= VS_IDLE;
            dir_up_reg <= 1'b0;
            level_reg <= VOL_RESET;
        end else if (clk_en) begin
            vol_reg <= vol_next;
            dir_up_reg <= dir_up_next;
            level_reg <= level_next;
        end
    end

    assign volume_change_request = (vol_reg == VS_HOLD);
    assign volume_level = level_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Mute and on/off toggles
    logic mute_reg, mute_next;
    logic on_reg, on_next;

    always_comb begin
        mute_next = mute_reg ^ mute_p;
        on_next = on_reg ^ power_p;
    end

    always_ff @(posedge sys_clk) begin
        if (run_rst) begin
            mute_reg <= MUTE_RESET;
        end else if (clk_en) begin
            mute_reg <= mute_next;
        end
        if (srst) begin
            on_reg <= POWER_ON_RESET;
        end else if (clk_en && !logic_reset) begin
            on_reg <= on_next;
        end
    end

    assign mute_state = mute_reg;
    assign mute_change_pulse = mute_p & ~run_rst;
    assign power_on_state = on_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Icons and digit
    function automatic logic [3:0] uip_bar(input logic [1:0] lvl);
        uip_bar = 4'hF >> (2'h3 - lvl);
    endfunction : uip_bar

    function automatic logic [6:0] uip_seg(input logic [3:0] v);
        unique case (v)
            4'h0: uip_seg = 7'h3F;
            4'h1: uip_seg = 7'h06;
            4'h2: uip_seg = 7'h5B;
            4'h3: uip_seg = 7'h4F;
            4'h4: uip_seg = 7'h66;
            4'h5: uip_seg = 7'h6D;
            4'h6: uip_seg = 7'h7D;
            4'h7: uip_seg = 7'h07;
            4'h8: uip_seg = 7'h7F;
            4'h9: uip_seg = 7'h6F;
            4'hA: uip_seg = 7'h77;
            4'hB: uip_seg = 7'h7C;
            4'hC: uip_seg = 7'h39;
            4'hD: uip_seg = 7'h5E;
            4'hE: uip_seg = 7'h79;
            4'hF: uip_seg = 7'h71;
        endcase
    endfunction : uip_seg

    uip_icons_t icons_reg, icons_next;
    logic [6:0] seg_reg, seg_next;
    logic [7:0] mode_dec;

    always_comb begin
        mode_dec = 8'h01 << play_mode_code;
        icons_next = '0;
        if (error_icon_request) begin
            icons_next.error = 1'b1;
        end else if (download_icon_request) begin
            icons_next.download = 1'b1;
        end else begin
            icons_next.play = mode_dec[MODE_PLAY];
            icons_next.rewind = mode_dec[MODE_REWIND];
            icons_next.stop = mode_dec[MODE_STOP];
            icons_next.ffwd = mode_dec[MODE_FFWD];
            icons_next.mute = mute_reg;
            icons_next.volume_bar = uip_bar(level_reg[5:4]);
            icons_next.battery_bar = uip_bar(battery_level);
        end
        seg_next = uip_seg(track_number);
    end

    always_ff @(posedge sys_clk) begin
        if (run_rst) begin
            icons_reg <= '0;
            seg_reg <= 7'h00;
        end else if (clk_en) begin
            icons_reg <= icons_next;
            seg_reg <= seg_next;
        end
    end

    assign icons = icons_reg;
    assign segments = seg_reg;
endmodule : uip_top
`default_nettype wire

/* File: logic/uip_pkg.sv */
// Shared constants and carriers for the user interface and power control block.
// Assumes one 20 MHz system clock and synchronous active-high reset.
package uip_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int VOL_W = 6;
    localparam logic [5:0] VOL_MIN = 6'h00;
    localparam logic [5:0] VOL_MAX = 6'h3F;
    localparam logic [5:0] VOL_RESET = 6'h20;
    localparam int WAIT_STATES = 2;
    localparam logic [1:0] WAIT_LAST = 2'h1;
    localparam logic [2:0] MODE_PLAY = 3'h0;
    localparam logic [2:0] MODE_REWIND = 3'h1;
    localparam logic [2:0] MODE_STOP = 3'h2;
    localparam logic [2:0] MODE_FFWD = 3'h3;
    localparam logic MUTE_RESET = 1'b0;
    localparam logic POWER_ON_RESET = 1'b1;

    typedef struct packed {
        logic volume_up;
        logic volume_down;
        logic mute;
        logic power;
    } uip_buttons_t;

    typedef struct packed {
        logic play;
        logic rewind;
        logic stop;
        logic ffwd;
        logic mute;
        logic error;
        logic download;
        logic [3:0] volume_bar;
        logic [3:0] battery_bar;
    } uip_icons_t;
endpackage : uip_pkg

/* File: logic/uip_edge.sv */
// Button synchroniser and rising-edge detector, one lane per button.
// Assumes buttons are debounced outside.
`timescale 1ns/100ps
`default_nettype none
module uip_edge
    import uip_pkg::*;
#(
    parameter int N = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [N-1:0] btn_in,
    output logic [N-1:0] rise_pulse
);
    logic [N-1:0] meta_reg, meta_next;
    logic [N-1:0] sync_reg, sync_next;
    logic [N-1:0] last_reg, last_next;

    always_comb begin
        meta_next = btn_in;
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else if (clk_en) begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_edge
            assign rise_pulse[i] = clk_en & sync_reg[i] & ~last_reg[i];
        end
    endgenerate
endmodule : uip_edge
`default_nettype wire

/* File: test/uip_top_sva.sv */
// Port checker for uip_top.
// Assumes one clock domain with synchronous srst.
`timescale 1ns/100ps
`default_nettype none
module uip_top_sva
    import uip_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic register_update_done,
    input wire logic error_icon_request,
    input wire logic supply_good,
    input wire logic shutdown_complete,
    input wire logic volume_change_request,
    input wire logic [5:0] volume_level,
    input wire logic mute_state,
    input wire logic mute_change_pulse,
    input wire logic power_on_state,
    input wire logic logic_reset,
    input wire logic shutdown_request,
    input wire logic supply_cutoff,
    input wire uip_icons_t icons
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////
    req_hold_a: assert property (volume_change_request && !register_update_done |=> volume_change_request)
        else $error("change request dropped");
    vol_step_a: assert property (!logic_reset && !$past(logic_reset) && volume_level != $past(volume_level)
        |-> 6'(volume_level - $past(volume_level)) inside {6'h01, 6'h3F} && volume_change_request)
        else $error("bad volume step");
    mute_flip_a: assert property (mute_change_pulse && !logic_reset |=> mute_state != $past(mute_state))
        else $error("mute did not toggle");
    pulse_once_a: assert property (mute_change_pulse |=> !mute_change_pulse)
        else $error("pulse too long");
    off_req_a: assert property ($fell(power_on_state) && !logic_reset
        |-> !supply_cutoff ##[1:2] shutdown_request)
        else $error("no shutdown on off");
    loss_req_a: assert property (!supply_good && !logic_reset && !supply_cutoff && !shutdown_complete
        |-> ##[1:2] shutdown_request)
        else $error("no shutdown on loss");
    cut_set_a: assert property (shutdown_request && shutdown_complete |=> supply_cutoff)
        else $error("no cutoff");
    cut_hold_a: assert property (supply_cutoff |=> supply_cutoff)
        else $error("cutoff released");
    reset_hold_a: assert property (logic_reset && !supply_good |=> logic_reset)
        else $error("reset released early");
    reset_wait_a: assert property ($fell(logic_reset) |-> $past(supply_good) && $past(supply_good, 2))
        else $error("reset wait wrong");
    err_icon_a: assert property (error_icon_request && !logic_reset
        |=> icons.error && !icons.download && !icons.play)
        else $error("error icon priority");
    cover property (volume_change_request && register_update_done);
    cover property ($rose(supply_cutoff));
    cover property (mute_change_pulse);
endmodule : uip_top_sva
`default_nettype wire

/* File: test/uip_main_model.sv */
// Main control logic model: answers volume and shutdown handshakes.
// Assumes slow is driven by the bench.
`timescale 1ns/100ps
`default_nettype none
module uip_main_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic volume_change_request,
    input wire logic shutdown_request,
    output logic register_update_done,
    output logic shutdown_complete
);
    int vol_cnt;
    int off_cnt;
    always @(posedge sys_clk) begin
        vol_cnt <= (srst || !volume_change_request) ? 0 : vol_cnt + 1;
        register_update_done <= !srst && volume_change_request && vol_cnt == (slow ? 6 : 0);
        off_cnt <= (srst || !shutdown_request) ? 0 : off_cnt + 1;
        shutdown_complete <= !srst && shutdown_request && off_cnt == (slow ? 9 : 1);
    end
endmodule : uip_main_model
`default_nettype wire

/* File: test/uip_top_bench.sv */
// Self-checking bench for uip_top.
// Assumes debounced buttons; clk_en held high except for the frozen-display check.
`timescale 1ns/100ps
`default_nettype none
module uip_top_bench;
    import uip_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic slow = 1'b0;
    logic clk_en = 1'b1;
    uip_buttons_t buttons = '0;
    logic [2:0] play_mode_code = 3'h0;
    logic error_icon_request = 1'b0;
    logic download_icon_request = 1'b0;
    logic [1:0] battery_level = 2'h0;
    logic [3:0] track_number = 4'h0;
    logic supply_good = 1'b0;
    logic register_update_done, shutdown_complete, volume_change_request, mute_state, mute_change_pulse;
    logic power_on_state, logic_reset, shutdown_request, supply_cutoff;
    logic [5:0] volume_level;
    logic [6:0] segments;
    uip_icons_t icons;
    int err_total = 0;
    int n_tests = 0;
    int vol = 32;
    logic mute = 1'b0;
    logic [15:0] lfsr = 16'h3600;
    logic [6:0] seg_tab [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F,
        7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    always #25 sys_clk = ~sys_clk;
    uip_top dut_u (.sys_clk, .srst, .clk_en, .buttons, .register_update_done, .play_mode_code,
        .error_icon_request, .download_icon_request, .battery_level, .track_number, .supply_good,
        .shutdown_complete, .volume_change_request, .volume_level, .mute_state, .mute_change_pulse,
        .power_on_state, .logic_reset, .shutdown_request, .supply_cutoff, .icons, .segments);
    uip_main_model model_u (.sys_clk, .srst, .slow, .volume_change_request, .shutdown_request,
        .register_update_done, .shutdown_complete);
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand
    function automatic uip_icons_t icon_of();
        uip_icons_t ic;
        ic = '0;
        if (error_icon_request) ic.error = 1'b1;
        else if (download_icon_request) ic.download = 1'b1;
        else begin
            {ic.play, ic.rewind, ic.stop, ic.ffwd} = play_mode_code[2] ? 4'h0 : 4'h8 >> play_mode_code[1:0];
            ic.mute = mute;
            ic.volume_bar = 4'hF >> (3 - vol / 16);
            ic.battery_bar = 4'hF >> (3 - battery_level);
        end
        return ic;
    endfunction : icon_of
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic press(input int lane, output int reqs, output int pulses);
        reqs = 0;
        pulses = 0;
        @(negedge sys_clk) buttons[lane] = 1'b1;
        for (int k = 0; k < 32; k++) begin
            @(negedge sys_clk);
            if (k == 1) begin
                buttons[lane] = 1'b0;
            end
            reqs += volume_change_request;
            pulses += mute_change_pulse;
        end
    endtask : press
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
    initial begin
        int reqs;
        int pulses;
        int step;
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("held", {logic_reset, power_on_state, volume_level}, {2'b11, 6'h20});
        supply_good = 1'b1;
        @(negedge sys_clk);
        check("reset wait", logic_reset, 1'b1);
        @(negedge sys_clk);
        check("reset off", logic_reset, 1'b0);
        $display("reset test done");
        for (int i = 0; i < 110; i++) begin
            lfsr = next_rand(lfsr);
            slow = lfsr[0];
            step = (i < 35 || (i >= 105 && lfsr[1])) ? 1 : -1;
            press(step > 0 ? 3 : 2, reqs, pulses);
            if (vol + step < 0 || vol + step > 63) step = 0;
            vol += step;
            check("volume", volume_level, vol[5:0]);
            check("request", reqs > 0, step != 0);
            check("idle", volume_change_request, 1'b0);
        end
        $display("volume test done");
        for (int i = 0; i < 3; i++) begin
            press(1, reqs, pulses);
            mute = ~mute;
            check("pulses", pulses, 1);
            check("mute", mute_state, mute);
        end
        $display("mute test done");
        for (int i = 0; i < 60; i++) begin
            lfsr = next_rand(lfsr);
            {play_mode_code, error_icon_request, download_icon_request, battery_level, track_number} = lfsr[10:0];
            @(negedge sys_clk);
            check("segments", segments, seg_tab[track_number]);
            check("icons", icons, icon_of());
        end
        clk_en = 1'b0;
        track_number = track_number + 4'h1;
        repeat (3) @(negedge sys_clk);
        check("frozen", segments, seg_tab[track_number - 4'h1]);
        clk_en = 1'b1;
        @(negedge sys_clk);
        check("thawed", segments, seg_tab[track_number]);
        $display("display test done");
        slow = 1'b1;
        press(0, reqs, pulses);
        check("power", power_on_state, 1'b0);
        check("cutoff", {supply_cutoff, shutdown_request}, 2'b10);
        srst = 1'b1;
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("preset", {power_on_state, supply_cutoff}, 2'b10);
        supply_good = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("loss", {shutdown_request, supply_cutoff}, 2'b10);
        repeat (20) @(negedge sys_clk);
        check("loss cutoff", supply_cutoff, 1'b1);
        $display("power test done");
        complete_run();
    end
endmodule : uip_top_bench
bind uip_top uip_top_sva chk_u (.sys_clk, .srst, .register_update_done, .error_icon_request, .supply_good,
    .shutdown_complete, .volume_change_request, .volume_level, .mute_state, .mute_change_pulse,
    .power_on_state, .logic_reset, .shutdown_request, .supply_cutoff, .icons);
`default_nettype wire
